// >>> test/tape_motion_model.sv
`timescale 1ns/1ns
// Tape coasts for a while after drive or wind stops, then reports rest
module tape_motion_model #(
	parameter int unsigned REST_CYCLES = 30
) (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic drive_on,
	input  wire logic wind_on,
	output logic      tape_at_rest
);
	int unsigned coast_reg;

	// Reload while moving, count down when left alone
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			coast_reg <= 0;
		end else if (drive_on || wind_on) begin
			coast_reg <= REST_CYCLES;
		end else if (coast_reg != 0) begin
			coast_reg <= coast_reg - 1;
		end
	end

	// Rest reported only once the reels have stopped
	assign tape_at_rest = (coast_reg == 0);
endmodule : tape_motion_model

// >>> test/tape_transport_bench.sv
`timescale 1ns/1ns
module tape_transport_bench;
	localparam logic [7:0] B_STOP = 8'h01, B_PAUSE = 8'h02, B_RUN = 8'h04, B_WIND = 8'h08;
	localparam logic [7:0] B_REV = 8'h10, B_REC = 8'h20, B_CANCEL = 8'h40, B_CLEAR = 8'h80;
	logic       CLK = 1'b0;
	logic       NRST = 1'b0;
	logic [7:0] btn = 8'h00;
	logic       MUTE_SW = 1'b0;
	logic       TENSION_LOST = 1'b0;
	logic       FOIL_SENSE = 1'b0;
	logic       LOAD_LEVER = 1'b0;
	logic [1:0] TAPE_BTN = 2'h0;
	logic [1:0] SOURCE_BTN = 2'h0;
	wire logic  TAPE_AT_REST, IND_STOP, IND_PAUSE, IND_RUN, IND_WIND, IND_RECORD;
	wire logic  FAULT_LAMP, AMP_ENABLE, MOTORS_ON, CAPSTAN_ON, BRAKES_ON, DRIVE_ON;
	wire logic  WIND_ON, WIND_INVERT, TREBLE_CUT, MONITOR_MUTE, ERASE_REC_ON;
	wire logic [1:0] MONITOR_SOURCE;
	wire logic [7:0] st = {IND_STOP, IND_PAUSE, IND_RUN, IND_WIND, IND_RECORD, FAULT_LAMP,
		DRIVE_ON, BRAKES_ON};
	int bad_count = 0;
	int n_compared = 0;
	int cycle_count = 0;

	tape_transport #(.TENSION_COUNT(20), .DEBOUNCE_COUNT(2), .CHANNELS(2)) i_dut (
		.CLK(CLK), .NRST(NRST), .STOP_BTN(btn[0]), .PAUSE_BTN(btn[1]), .RUN_BTN(btn[2]),
		.WIND_BTN(btn[3]), .REVERSE_BTN(btn[4]), .RECORD_BTN(btn[5]), .CANCEL_BTN(btn[6]),
		.MUTE_SW(MUTE_SW), .TENSION_LOST(TENSION_LOST), .FOIL_SENSE(FOIL_SENSE),
		.TAPE_AT_REST(TAPE_AT_REST), .LOAD_LEVER(LOAD_LEVER), .FAULT_CLEAR(btn[7]),
		.TAPE_BTN(TAPE_BTN), .SOURCE_BTN(SOURCE_BTN), .IND_STOP(IND_STOP),
		.IND_PAUSE(IND_PAUSE), .IND_RUN(IND_RUN), .IND_WIND(IND_WIND),
		.IND_RECORD(IND_RECORD), .FAULT_LAMP(FAULT_LAMP), .AMP_ENABLE(AMP_ENABLE),
		.MOTORS_ON(MOTORS_ON), .CAPSTAN_ON(CAPSTAN_ON), .BRAKES_ON(BRAKES_ON),
		.DRIVE_ON(DRIVE_ON), .WIND_ON(WIND_ON), .WIND_INVERT(WIND_INVERT),
		.TREBLE_CUT(TREBLE_CUT), .MONITOR_MUTE(MONITOR_MUTE), .ERASE_REC_ON(ERASE_REC_ON),
		.MONITOR_SOURCE(MONITOR_SOURCE)
	);

	tape_motion_model #(.REST_CYCLES(30)) i_motion (
		.clk(CLK), .nrst(NRST), .drive_on(DRIVE_ON), .wind_on(WIND_ON),
		.tape_at_rest(TAPE_AT_REST)
	);

	// Clock and cycle ceiling
	always #2 CLK = ~CLK;
	always @(posedge CLK) begin
		cycle_count++;
		if (cycle_count == 3000) begin
			bad_count++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("ERROR %0t ns: seen %h expected %h", $time, seen, want);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : cyc

	// Hold a button set long enough to debounce, then release
	task automatic press(input logic [7:0] m);
		@(posedge CLK);
		btn <= m;
		cyc(8);
		@(posedge CLK);
		btn <= 8'h00;
		cyc(8);
	endtask : press

	task automatic t_record();
		press(B_RUN);
		chk({CAPSTAN_ON, st[6:0]}, 8'ha2);
		press(B_REC);
		chk(st, 8'h22);
		press(B_REC | B_RUN);
		chk({ERASE_REC_ON, st[6:0]}, 8'ha2 | 8'h08);
		press(B_PAUSE);
		chk(st, 8'h49);
		press(B_RUN);
		chk(st, 8'h2a);
		press(B_CANCEL);
		chk(st, 8'h22);
	endtask : t_record

	task automatic t_wind();
		press(B_REC | B_PAUSE);
		chk(st, 8'h49);
		press(B_WIND);
		chk(st, 8'h10);
		chk({5'h0, WIND_ON, TREBLE_CUT, MONITOR_MUTE}, 8'h06);
		@(posedge CLK);
		MUTE_SW <= 1'b1;
		cyc(8);
		chk({6'h0, TREBLE_CUT, MONITOR_MUTE}, 8'h03);
		@(posedge CLK);
		MUTE_SW <= 1'b0;
		cyc(8);
		chk({6'h0, TREBLE_CUT, MONITOR_MUTE}, 8'h02);
	endtask : t_wind

	task automatic t_brake_run();
		press(B_RUN);
		chk(st, 8'h41);
		cyc(40);
		chk(st, 8'h22);
		press(B_WIND);
		press(B_PAUSE);
		chk(st, 8'h41);
	endtask : t_brake_run

	task automatic t_reverse();
		press(B_STOP);
		chk({MOTORS_ON, CAPSTAN_ON, AMP_ENABLE, 5'h0}, 8'h20);
		@(posedge CLK);
		btn <= B_REV;
		cyc(8);
		chk({WIND_INVERT, st[6:0]}, 8'h90);
		@(posedge CLK);
		btn <= 8'h00;
		cyc(8);
		chk({WIND_INVERT, st[6:0]}, 8'h10);
	endtask : t_reverse

	task automatic t_priority();
		press(B_STOP | B_RUN);
		chk(st, 8'h80);
		press(B_PAUSE | B_WIND);
		chk(st, 8'h41);
		press(B_WIND | B_RUN);
		chk(st, 8'h10);
	endtask : t_priority

	task automatic t_faults();
		press(B_RUN);
		cyc(40);
		@(posedge CLK);
		TENSION_LOST <= 1'b1;
		cyc(10);
		@(posedge CLK);
		TENSION_LOST <= 1'b0;
		cyc(30);
		chk(st, 8'h22);
		@(posedge CLK);
		TENSION_LOST <= 1'b1;
		cyc(40);
		chk({6'h0, FAULT_LAMP, DRIVE_ON}, 8'h02);
		press(B_RUN);
		chk({6'h0, FAULT_LAMP, DRIVE_ON}, 8'h02);
		@(posedge CLK);
		TENSION_LOST <= 1'b0;
		cyc(8);
		press(B_CLEAR);
		chk({7'h0, FAULT_LAMP}, 8'h00);
		@(posedge CLK);
		btn <= B_WIND;
		TENSION_LOST <= 1'b1;
		cyc(40);
		chk({7'h0, FAULT_LAMP}, 8'h00);
		@(posedge CLK);
		btn <= 8'h00;
		TENSION_LOST <= 1'b0;
		cyc(8);
		press(B_PAUSE);
		@(posedge CLK);
		FOIL_SENSE <= 1'b1;
		cyc(8);
		@(posedge CLK);
		FOIL_SENSE <= 1'b0;
		cyc(8);
		chk(st, 8'h84);
		press(B_CLEAR);
		chk(st, 8'h80);
	endtask : t_faults

	task automatic t_panel();
		@(posedge CLK);
		LOAD_LEVER <= 1'b1;
		cyc(8);
		press(B_RUN);
		chk(st, 8'h80);
		@(posedge CLK);
		LOAD_LEVER <= 1'b0;
		SOURCE_BTN <= 2'b01;
		cyc(8);
		@(posedge CLK);
		SOURCE_BTN <= 2'b00;
		cyc(8);
		chk({6'h0, MONITOR_SOURCE}, 8'h02);
		@(posedge CLK);
		TAPE_BTN <= 2'b01;
		cyc(8);
		@(posedge CLK);
		TAPE_BTN <= 2'b00;
		cyc(8);
		chk({6'h0, MONITOR_SOURCE}, 8'h03);
		@(posedge CLK);
		SOURCE_BTN <= 2'b10;
		cyc(8);
		@(posedge CLK);
		SOURCE_BTN <= 2'b00;
		cyc(8);
		chk({6'h0, MONITOR_SOURCE}, 8'h01);
		@(posedge CLK);
		TAPE_BTN <= 2'b10;
		SOURCE_BTN <= 2'b10;
		cyc(8);
		@(posedge CLK);
		TAPE_BTN <= 2'b00;
		SOURCE_BTN <= 2'b00;
		cyc(8);
		chk({6'h0, MONITOR_SOURCE}, 8'h03);
	endtask : t_panel

	// Main sequence
	initial begin
		repeat (8) @(posedge CLK);
		NRST <= 1'b1;
		cyc(2);
		chk(st, 8'h80);
		chk({5'h0, AMP_ENABLE, MONITOR_SOURCE}, 8'h07);
		t_record();
		t_wind();
		t_brake_run();
		t_reverse();
		t_priority();
		t_faults();
		t_panel();
		give_verdict();
	end
endmodule : tape_transport_bench

// >>> test/transport_properties.sv
`timescale 1ns/1ns
// Port-level checks on the deck controller outputs
module transport_properties (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic LOAD_LEVER,
	input wire logic IND_STOP,
	input wire logic IND_PAUSE,
	input wire logic IND_RUN,
	input wire logic IND_WIND,
	input wire logic IND_RECORD,
	input wire logic FAULT_LAMP,
	input wire logic AMP_ENABLE,
	input wire logic MOTORS_ON,
	input wire logic CAPSTAN_ON,
	input wire logic BRAKES_ON,
	input wire logic DRIVE_ON,
	input wire logic WIND_ON,
	input wire logic MONITOR_MUTE
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);

	property p_stop;
		IND_STOP |-> !MOTORS_ON && !CAPSTAN_ON && AMP_ENABLE;
	endproperty
	a_stop: assert property (p_stop) else $error("motors on while stopped");
	property p_pause;
		IND_PAUSE |-> BRAKES_ON && MOTORS_ON && CAPSTAN_ON && !DRIVE_ON;
	endproperty
	a_pause: assert property (p_pause) else $error("pause outputs wrong");
	property p_run;
		IND_RUN |-> DRIVE_ON && !BRAKES_ON;
	endproperty
	a_run: assert property (p_run) else $error("run outputs wrong");
	property p_leave_stop;
		$fell(IND_STOP) |-> CAPSTAN_ON && MOTORS_ON;
	endproperty
	a_leave_stop: assert property (p_leave_stop) else $error("capstan late");
	property p_mute;
		MONITOR_MUTE |-> WIND_ON;
	endproperty
	a_mute: assert property (p_mute) else $error("mute outside winding");
	property p_ind;
		$onehot({IND_STOP, IND_PAUSE, IND_RUN, IND_WIND});
	endproperty
	a_ind: assert property (p_ind) else $error("state indicators not one-hot");
	property p_load;
		LOAD_LEVER [*8] ##1 LOAD_LEVER |-> IND_STOP;
	endproperty
	a_load: assert property (p_load) else $error("deck active while loading");
	property p_rec_clear;
		$rose(IND_WIND) || $rose(IND_STOP) |-> !IND_RECORD;
	endproperty
	a_rec_clear: assert property (p_rec_clear) else $error("record kept");
	property p_fault;
		FAULT_LAMP [*2] |-> !DRIVE_ON && !WIND_ON;
	endproperty
	a_fault: assert property (p_fault) else $error("tape moving under fault");
endmodule : transport_properties

bind tape_transport transport_properties i_props (
	.CLK(CLK), .NRST(NRST), .LOAD_LEVER(LOAD_LEVER), .IND_STOP(IND_STOP),
	.IND_PAUSE(IND_PAUSE), .IND_RUN(IND_RUN), .IND_WIND(IND_WIND),
	.IND_RECORD(IND_RECORD), .FAULT_LAMP(FAULT_LAMP), .AMP_ENABLE(AMP_ENABLE),
	.MOTORS_ON(MOTORS_ON), .CAPSTAN_ON(CAPSTAN_ON), .BRAKES_ON(BRAKES_ON),
	.DRIVE_ON(DRIVE_ON), .WIND_ON(WIND_ON), .MONITOR_MUTE(MONITOR_MUTE)
);

// >>> verilog/input_conditioner.sv
`timescale 1ns/1ns
// Two-flop synchroniser followed by a counting debouncer for each input
module input_conditioner #(
	parameter int unsigned WIDTH  = 8,
	parameter int unsigned CYCLES = 16
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] raw,
	output logic      [WIDTH-1:0] clean
);
	import transport_pkg::*;

	localparam int unsigned CW = $clog2(CYCLES + 1);

	if (WIDTH < 1 || CYCLES < 1) begin : g_bad_params
		$error("input_conditioner: bad parameters");
	end

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// ----------------------------------------
	// Synchroniser
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= raw;
			sync_reg <= meta_reg;
		end
	end

	// ----------------------------------------
	// Debounce: accept a change once stable
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic [CW-1:0] cnt_reg;
			logic          clean_reg;
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					cnt_reg   <= '0;
					clean_reg <= 1'b0;
				end else if (sync_reg[i] == clean_reg) begin
					cnt_reg <= '0;
				end else if (cnt_reg == CW'(CYCLES - 1)) begin
					cnt_reg   <= '0;
					clean_reg <= sync_reg[i];
				end else begin
					cnt_reg <= cnt_reg + CW'(1);
				end
			end
			assign clean[i] = clean_reg;
		end
	endgenerate

endmodule : input_conditioner

// >>> verilog/tape_transport.sv
`timescale 1ns/1ns
// Operation
// - Run during wind: pause with brakes, then run once tape rests.
// - Pause: all motors on, capstan turning, both reel brakes held.
// - Run button puts transport running at selected speed, brakes off.
// - Stop to run directly allowed; capstan energised at that moment.
// - While winding, assert the treble reduction output.
// - From wind, pause brakes and stops; run takes brake-then-run path.
// - Held reverse button winds opposite to wind control, same speed.
// - Reverse accepted from any state; release enters normal winding.
// - Mute switch silences monitor during winding; cleared switch restores.
// - Record entered only with record pressed together with run or pause.
// - With record lit, pause or run stop/start tape, record continues.
// - Cancel ends erase/record, transport stays paused or running.
// - Wind, reverse or stop clears the record condition.
// - Stop de-energises motors and mechanics, amplifiers stay enabled.
// - Tension loss stops drive only after about one second persisting.
// - Foil on sense guide forces the stopped state.
// - Auto stop lights fault lamp, blocks operation until fault cleared.
// - Both auto stops disabled while wind or reverse held.
// - One indicator per deck state always shows current state.
// - Per channel monitor picks replay or input by last tape/source press.
// - After reset: stopped, amplifiers on, mechanics off.
// - Load lever in loading position refuses every transport function.
module tape_transport #(
	parameter int unsigned TENSION_COUNT  = transport_pkg::TENSION_CYCLES,
	parameter int unsigned DEBOUNCE_COUNT = transport_pkg::DEBOUNCE_CYCLES,
	parameter int unsigned CHANNELS       = 2
) (
	input  wire logic                CLK,
	input  wire logic                NRST,
	input  wire logic                STOP_BTN,
	input  wire logic                PAUSE_BTN,
	input  wire logic                RUN_BTN,
	input  wire logic                WIND_BTN,
	input  wire logic                REVERSE_BTN,
	input  wire logic                RECORD_BTN,
	input  wire logic                CANCEL_BTN,
	input  wire logic                MUTE_SW,
	input  wire logic                TENSION_LOST,
	input  wire logic                FOIL_SENSE,
	input  wire logic                TAPE_AT_REST,
	input  wire logic                LOAD_LEVER,
	input  wire logic                FAULT_CLEAR,
	input  wire logic [CHANNELS-1:0] TAPE_BTN,
	input  wire logic [CHANNELS-1:0] SOURCE_BTN,
	output logic                     IND_STOP,
	output logic                     IND_PAUSE,
	output logic                     IND_RUN,
	output logic                     IND_WIND,
	output logic                     IND_RECORD,
	output logic                     FAULT_LAMP,
	output logic                     AMP_ENABLE,
	output logic                     MOTORS_ON,
	output logic                     CAPSTAN_ON,
	output logic                     BRAKES_ON,
	output logic                     DRIVE_ON,
	output logic                     WIND_ON,
	output logic                     WIND_INVERT,
	output logic                     TREBLE_CUT,
	output logic                     MONITOR_MUTE,
	output logic                     ERASE_REC_ON,
	output logic [CHANNELS-1:0]      MONITOR_SOURCE
);
	import transport_pkg::*;

	localparam int unsigned NIN = IN_COUNT + 2 * CHANNELS - 2;
	localparam int unsigned TW  = $clog2(TENSION_COUNT + 1);

	// Port packing of the extra channels needs at least two channels
	if (TENSION_COUNT < 1 || DEBOUNCE_COUNT < 1 || CHANNELS < 2) begin : g_bad_params
		$error("tape_transport: bad parameters");
	end

	// ----------------------------------------
	// Input conditioning
	// ----------------------------------------
	logic [NIN-1:0] raw_in;
	logic [NIN-1:0] clean_in;
	logic [NIN-1:0] prev_reg;
	logic [NIN-1:0] press;

	assign raw_in = {SOURCE_BTN[CHANNELS-1:1], TAPE_BTN[CHANNELS-1:1], SOURCE_BTN[0],
		TAPE_BTN[0], FAULT_CLEAR, LOAD_LEVER, TAPE_AT_REST, FOIL_SENSE, TENSION_LOST,
		MUTE_SW, CANCEL_BTN, RECORD_BTN, REVERSE_BTN, WIND_BTN, RUN_BTN, PAUSE_BTN,
		STOP_BTN};

	input_conditioner #(
		.WIDTH  (NIN),
		.CYCLES (DEBOUNCE_COUNT)
	) u_cond (
		.clk   (CLK),
		.nrst  (NRST),
		.raw   (raw_in),
		.clean (clean_in)
	);

	// Previous level for press edge detection
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= clean_in;
		end
	end
	assign press = clean_in & ~prev_reg;

	logic stop_p, pause_p, run_p, wind_p, rec_p, cancel_p, fclr_p;
	logic rev_lvl, wind_lvl, slack_lvl, foil_lvl, rest_lvl, load_lvl, mute_lvl;
	logic [CHANNELS-1:0] tape_p;
	logic [CHANNELS-1:0] src_p;

	assign stop_p    = press[IN_STOP];
	assign pause_p   = press[IN_PAUSE];
	assign run_p     = press[IN_RUN];
	assign wind_p    = press[IN_WIND];
	assign rec_p     = press[IN_RECORD];
	assign cancel_p  = press[IN_CANCEL];
	assign fclr_p    = press[IN_FAULT_CLR];
	assign rev_lvl   = clean_in[IN_REVERSE];
	assign wind_lvl  = clean_in[IN_WIND];
	assign mute_lvl  = clean_in[IN_MUTE];
	assign slack_lvl = clean_in[IN_SLACK];
	assign foil_lvl  = clean_in[IN_FOIL];
	assign rest_lvl  = clean_in[IN_AT_REST];
	assign load_lvl  = clean_in[IN_LOAD];

	// Channel 0 in the fixed layout; later tape presses, then source presses
	always_comb begin
		tape_p    = '0;
		src_p     = '0;
		tape_p[0] = press[IN_TAPE_SEL];
		src_p[0]  = press[IN_SRC_SEL];
		for (int c = 1; c < CHANNELS; c++) begin
			tape_p[c] = press[IN_COUNT + c - 1];
			src_p[c]  = press[IN_COUNT + CHANNELS + c - 2];
		end
	end

	// ----------------------------------------
	// Automatic stops
	// ----------------------------------------
	logic [TW-1:0] slack_cnt_reg;
	logic          fault_reg;
	logic          stops_armed;
	logic          slack_trip;
	logic          foil_trip;

	assign stops_armed = !(wind_lvl || rev_lvl);

	// Tension loss must persist before tripping
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			slack_cnt_reg <= '0;
		end else if (!slack_lvl || !stops_armed) begin
			slack_cnt_reg <= '0;
		end else if (slack_cnt_reg != TW'(TENSION_COUNT)) begin
			slack_cnt_reg <= slack_cnt_reg + TW'(1);
		end
	end

	assign slack_trip = stops_armed && slack_cnt_reg == TW'(TENSION_COUNT);
	assign foil_trip  = stops_armed && foil_lvl;

	// Fault latch; a new trip wins over the clear
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			fault_reg <= 1'b0;
		end else if (slack_trip || foil_trip) begin
			fault_reg <= 1'b1;
		end else if (fclr_p) begin
			fault_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Transport state machine
	// ----------------------------------------
	deck_state_type state_reg;
	deck_state_type state_next;
	logic           blocked;

	assign blocked = load_lvl || fault_reg;

	always_comb begin
		state_next = state_reg;
		if (slack_trip || foil_trip) begin
			state_next = ST_STOP;
		end else if (blocked) begin
			state_next = state_reg == ST_STOP ? ST_STOP : ST_PAUSE;
			if (load_lvl) state_next = ST_STOP;
		end else if (rev_lvl) begin
			state_next = ST_REVERSE;
		end else if (state_reg == ST_REVERSE) begin
			state_next = ST_WIND;
		end else if (stop_p) begin
			state_next = ST_STOP;
		end else if (pause_p) begin
			state_next = ST_PAUSE;
		end else if (wind_p) begin
			state_next = ST_WIND;
		end else if (run_p) begin
			unique case (state_reg)
				ST_WIND: state_next = ST_BRAKE_TO_RUN;
				default: state_next = ST_RUN;
			endcase
		end else if (state_reg == ST_BRAKE_TO_RUN && rest_lvl) begin
			state_next = ST_RUN;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_reg <= ST_STOP;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Record condition
	// ----------------------------------------
	logic record_reg;
	logic record_next;

	// Next record condition, so the lamp moves with the state indicators
	always_comb begin
		record_next = record_reg;
		if (state_next == ST_STOP || state_next == ST_WIND ||
				state_next == ST_REVERSE || wind_p || rev_lvl || stop_p) begin
			record_next = 1'b0;
		end else if (cancel_p) begin
			record_next = 1'b0;
		end else if (rec_p && (clean_in[IN_RUN] || clean_in[IN_PAUSE]) && !blocked) begin
			record_next = 1'b1;
		end // pause/run leave record untouched
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			record_reg <= 1'b0;
		end else begin
			record_reg <= record_next;
		end
	end

	// ----------------------------------------
	// Monitor selection per channel
	// ----------------------------------------
	logic [CHANNELS-1:0] mon_reg;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			mon_reg <= {CHANNELS{MON_RESET_TAPE}};
		end else begin
			mon_reg <= (mon_reg | tape_p) & ~(src_p & ~tape_p);
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	logic winding;
	assign winding = state_next == ST_WIND || state_next == ST_REVERSE;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			IND_STOP     <= 1'b1;
			IND_PAUSE    <= 1'b0;
			IND_RUN      <= 1'b0;
			IND_WIND     <= 1'b0;
			AMP_ENABLE   <= 1'b1;
			MOTORS_ON    <= 1'b0;
			CAPSTAN_ON   <= 1'b0;
			BRAKES_ON    <= 1'b0;
			DRIVE_ON     <= 1'b0;
			WIND_ON      <= 1'b0;
			WIND_INVERT  <= 1'b0;
			TREBLE_CUT   <= 1'b0;
			MONITOR_MUTE <= 1'b0;
		end else begin
			IND_STOP     <= state_next == ST_STOP;
			IND_PAUSE    <= state_next == ST_PAUSE || state_next == ST_BRAKE_TO_RUN;
			IND_RUN      <= state_next == ST_RUN;
			IND_WIND     <= winding;
			AMP_ENABLE   <= 1'b1;
			MOTORS_ON    <= state_next != ST_STOP;
			CAPSTAN_ON   <= state_next != ST_STOP;
			BRAKES_ON    <= state_next == ST_PAUSE || state_next == ST_BRAKE_TO_RUN;
			DRIVE_ON     <= state_next == ST_RUN;
			WIND_ON      <= winding;
			WIND_INVERT  <= state_next == ST_REVERSE;
			TREBLE_CUT   <= winding;
			MONITOR_MUTE <= winding && mute_lvl;
		end
	end

	// Record, fault and monitor outputs
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			IND_RECORD     <= 1'b0;
			ERASE_REC_ON   <= 1'b0;
			FAULT_LAMP     <= 1'b0;
			MONITOR_SOURCE <= {CHANNELS{MON_RESET_TAPE}};
		end else begin
			IND_RECORD     <= record_next;
			ERASE_REC_ON   <= record_next && state_next == ST_RUN;
			FAULT_LAMP     <= fault_reg;
			MONITOR_SOURCE <= mon_reg;
		end
	end

endmodule : tape_transport

// >>> verilog/transport_pkg.sv
package transport_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS    = 4;
	localparam int unsigned TENSION_DELAY_MS = 1000;
	localparam int unsigned TENSION_CYCLES   =
		TENSION_DELAY_MS * (1000000 / CLK_PERIOD_NS);
	localparam int unsigned DEBOUNCE_US      = 1000;
	localparam int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_US * (1000 / CLK_PERIOD_NS);

	// ----------------------------------------
	// Input vector layout
	// ----------------------------------------
	localparam int unsigned IN_COUNT     = 15;
	localparam int unsigned IN_STOP      = 0;
	localparam int unsigned IN_PAUSE     = 1;
	localparam int unsigned IN_RUN       = 2;
	localparam int unsigned IN_WIND      = 3;
	localparam int unsigned IN_REVERSE   = 4;
	localparam int unsigned IN_RECORD    = 5;
	localparam int unsigned IN_CANCEL    = 6;
	localparam int unsigned IN_MUTE      = 7;
	localparam int unsigned IN_SLACK     = 8;
	localparam int unsigned IN_FOIL      = 9;
	localparam int unsigned IN_AT_REST   = 10;
	localparam int unsigned IN_LOAD      = 11;
	localparam int unsigned IN_FAULT_CLR = 12;
	localparam int unsigned IN_TAPE_SEL  = 13;
	localparam int unsigned IN_SRC_SEL   = 14;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [14:0] IN_RESET_VALUE = 15'h0000;
	localparam logic        MON_RESET_TAPE = 1'b1;

	// ----------------------------------------
	// Deck states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_STOP,
		ST_PAUSE,
		ST_RUN,
		ST_WIND,
		ST_REVERSE,
		ST_BRAKE_TO_RUN
	} deck_state_type;

endpackage : transport_pkg
